// >>> core/tmr_ctrl.sv
// 16-bit timer/event counter: mode, capture/compare control, output and flags
// Notes on behaviour
// - counting starts once the mode bits are nonzero; mode zero stops it
// - 00 stop and zero, 01 free run, 10 clear on input a, 11 on match
// - output toggles on either match; with inversion timing also on input a
// - compare registers interrupt on match, capture registers on the count clock after their load
// - overflow flag in mode-control bit 0 is set on counter overflow
// - overflow flag sets on the ffff to 0000 step in every running mode, except when a pending input a clear makes that step
// - clearing the flag before the counter reaches 0001 is undone
// - capture loads on one count clock, its interrupt follows on the next
// - a stopped timer counts nothing; a pending capture interrupt can still fire on the leftover tick in its first stopped cycle
// - control bit 2 makes the second register capture when set
// - control bit 0 makes the first register capture when set
// - control bit 1 picks input b edge or reverse-phase input a edge
// - reverse-phase capture with both-edge input a does not capture
// - reset clears mode, capture/compare and output control to 00
// - output control holds inversion, enable and one-shot enable bits; set, reset and trigger act once and are not held
// - the four control registers take both single-bit and whole-byte writes; the capture/compare registers take whole writes only
// - input a edge select: 00 fall, 01 rise, 11 both, 10 none
// - the software one-shot trigger clears itself and reads zero
`timescale 1ns/100ps
`default_nettype none
module tmr_ctrl (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic [15:0] cpu_addr,
	input  wire logic        cpu_wr,
	input  wire logic        cpu_bit_wr,
	input  wire logic [2:0]  cpu_bit_sel,
	input  wire logic        cpu_bit_val,
	input  wire logic [15:0] cpu_wdata,
	input  wire logic        cpu_rd,
	output logic      [15:0] cpu_rdata,
	input  wire logic        timer_input_a,
	input  wire logic        timer_input_b,
	output logic             timer_output_pin,
	output logic             match_capture_irq_a,
	output logic             match_capture_irq_b
);
	import tmr_pkg::*;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] bit_merge(input logic [7:0] cur, input logic [2:0] sel,
	                                         input logic val);
		logic [7:0] r;
		r      = cur;
		r[sel] = val;
		return r;
	endfunction : bit_merge

	function automatic logic edge_hit(input tmr_edge_t sel, input logic rise,
	                                  input logic fall);
		return ((sel == EDGE_RISE | sel == EDGE_BOTH) & rise) |
		       ((sel == EDGE_FALL | sel == EDGE_BOTH) & fall);
	endfunction : edge_hit

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [3:0]  tmc_q;
	logic [3:0]  tmc_d;
	logic [7:0]  prm_q;
	logic [7:0]  prm_d;
	logic [2:0]  crc_q;
	logic [2:0]  crc_d;
	logic [7:0]  toc_q;
	logic [7:0]  toc_d;
	logic [15:0] cr0_q;
	logic [15:0] cr0_d;
	logic [15:0] cr1_q;
	logic [15:0] cr1_d;
	logic [15:0] cnt_q;
	logic [15:0] cnt_d;
	logic        ovf_q;
	logic        ovf_d;
	logic        ovf_win_q;
	logic        ovf_win_d;
	logic        clr_pend_q;
	logic        clr_pend_d;
	logic        cap0_pend_q;
	logic        cap0_pend_d;
	logic        cap1_pend_q;
	logic        cap1_pend_d;
	logic        irq0_pend_q;
	logic        irq0_pend_d;
	logic        irq1_pend_q;
	logic        irq1_pend_d;
	logic        ff_q;
	logic        ff_d;
	logic        os_arm_q;
	logic        os_arm_d;
	logic [15:0] rdata_d;

	// ----------------------------------------------------------------
	// write decode
	// ----------------------------------------------------------------
	wire         any_wr   = cpu_wr | cpu_bit_wr;
	wire         wr_tmc   = any_wr & (cpu_addr == ADDR_TMC);
	wire         wr_prm   = any_wr & (cpu_addr == ADDR_PRM);
	wire         wr_crc   = any_wr & (cpu_addr == ADDR_CRC);
	wire         wr_toc   = any_wr & (cpu_addr == ADDR_TOC);
	wire         wr_cr0   = cpu_wr & (cpu_addr == ADDR_CR0);
	wire         wr_cr1   = cpu_wr & (cpu_addr == ADDR_CR1);
	wire [7:0]   tmc_cur  = {4'h0, tmc_q[3:1], ovf_q};
	wire [7:0]   toc_cur  = toc_q & TOC_KEEP;
	// single-bit writes modify the value as it reads back
	wire [7:0]   tmc_wv   = cpu_bit_wr ? bit_merge(tmc_cur, cpu_bit_sel, cpu_bit_val)
	                                   : cpu_wdata[7:0];
	wire [7:0]   prm_wv   = cpu_bit_wr ? bit_merge(prm_q, cpu_bit_sel, cpu_bit_val)
	                                   : cpu_wdata[7:0];
	wire [7:0]   crc_wv   = cpu_bit_wr ? bit_merge({5'h00, crc_q}, cpu_bit_sel, cpu_bit_val)
	                                   : cpu_wdata[7:0];
	wire [7:0]   toc_wv   = cpu_bit_wr ? bit_merge(toc_cur, cpu_bit_sel, cpu_bit_val)
	                                   : cpu_wdata[7:0];

	// ----------------------------------------------------------------
	// field decode
	// ----------------------------------------------------------------
	wire         inv_timing = tmc_q[TMC_INV];
	tmr_mode_t   mode;
	tmr_edge_t   es_a;
	tmr_edge_t   es_b;
	tmr_cks_t    cks;
	assign mode = tmr_mode_t'(tmc_q[TMC_MODE_LO +: 2]);
	assign es_a = tmr_edge_t'(prm_q[PRM_ES0_LO +: 2]);
	assign es_b = tmr_edge_t'(prm_q[PRM_ES1_LO +: 2]);
	assign cks  = tmr_cks_t'(prm_q[PRM_CKS_LO +: 2]);

	wire         running  = mode != MODE_STOP;
	wire         cap0_sel = crc_q[CRC_CAP0];
	wire         trig0_a  = crc_q[CRC_TRIG0];
	wire         cap1_sel = crc_q[CRC_CAP1];
	wire         toe      = toc_q[TOC_TOE];
	wire         inv0_en  = toc_q[TOC_INV0];
	wire         inv1_en  = toc_q[TOC_INV1];
	wire         os_mode  = toc_q[TOC_OSPE];
	wire         lvs_wr   = wr_toc & toc_wv[TOC_LVS] & ~toc_wv[TOC_LVR];
	wire         lvr_wr   = wr_toc & toc_wv[TOC_LVR] & ~toc_wv[TOC_LVS];
	wire         ospt_wr  = wr_toc & toc_wv[TOC_OSPT];

	// ----------------------------------------------------------------
	// pins and count clock
	// ----------------------------------------------------------------
	logic        a_rise;
	logic        a_fall;
	logic        b_rise;
	logic        b_fall;
	logic        tick;

	tmr_pin_sync u_sync_a (
		.clk  (clk),
		.rst_b(rst_b),
		.pin  (timer_input_a),
		.rise (a_rise),
		.fall (a_fall)
	);

	tmr_pin_sync u_sync_b (
		.clk  (clk),
		.rst_b(rst_b),
		.pin  (timer_input_b),
		.rise (b_rise),
		.fall (b_fall)
	);

	// edges are ignored altogether while the timer is stopped
	wire         a_valid = running & edge_hit(es_a, a_rise, a_fall);
	wire         b_valid = running & edge_hit(es_b, b_rise, b_fall);
	// reverse phase: opposite edge, and nothing when both edges are chosen
	wire         a_rev   = running & ((es_a == EDGE_FALL & a_rise) |
	                                  (es_a == EDGE_RISE & a_fall));

	tmr_count_tick u_tick (
		.clk     (clk),
		.rst_b   (rst_b),
		.run     (running),
		.sel     (cks),
		.ext_edge(a_valid),
		.tick    (tick)
	);

	// ----------------------------------------------------------------
	// counter, matches and overflow
	// ----------------------------------------------------------------
	wire         match0_raw = running & tick & (cnt_q == cr0_q);
	wire         match0     = match0_raw & ~cap0_sel;
	wire         match1     = running & tick & (cnt_q == cr1_q) & ~cap1_sel;
	wire         clr_now    = clr_pend_q | (mode == MODE_CLR_MATCH & match0_raw);
	wire         ovf_evt    = running & tick & (cnt_q == CNT_MAX) & ~clr_pend_q;

	always_comb begin
		cnt_d = cnt_q;
		if (!running) begin
			cnt_d = CNT_ZERO;
		end else if (tick) begin
			cnt_d = clr_now ? CNT_ZERO : cnt_q + 16'h0001;
		end
	end

	// an edge in the same cycle as the tick waits for the following tick
	assign clr_pend_d = running & ((mode == MODE_CLR_EDGE & a_valid) |
	                               (clr_pend_q & ~tick));
	// window between the overflow step and the step to 0001
	assign ovf_win_d  = running & (tick ? ovf_evt : ovf_win_q);
	always_comb begin
		ovf_d = ovf_q;
		if (wr_tmc) begin
			ovf_d = tmc_wv[TMC_OVF];
		end
		if (ovf_evt | ovf_win_q) begin
			ovf_d = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// capture
	// ----------------------------------------------------------------
	wire         cap0_trig = cap0_sel & (trig0_a ? a_rev : b_valid);
	wire         cap1_trig = cap1_sel & a_valid;
	assign cap0_pend_d = running & (cap0_trig | (cap0_pend_q & ~tick));
	assign cap1_pend_d = running & (cap1_trig | (cap1_pend_q & ~tick));
	wire         cap0_load = tick & cap0_pend_q;
	wire         cap1_load = tick & cap1_pend_q;
	assign irq0_pend_d = running & (cap0_load | (irq0_pend_q & ~tick));
	assign irq1_pend_d = running & (cap1_load | (irq1_pend_q & ~tick));
	// capture wins over a software write landing in the same cycle
	assign cr0_d = cap0_load ? cnt_q : (wr_cr0 ? cpu_wdata : cr0_q);
	assign cr1_d = cap1_load ? cnt_q : (wr_cr1 ? cpu_wdata : cr1_q);
	wire         irq0_d = match0 | (tick & irq0_pend_q);
	wire         irq1_d = match1 | (tick & irq1_pend_q);

	// ----------------------------------------------------------------
	// timer output
	// ----------------------------------------------------------------
	wire         tog_evt = (inv0_en & match0) | (inv1_en & match1) |
	                       (inv_timing & a_valid);
	// in one-shot mode toggles only pass between the trigger and the first match of the first register
	wire         tog_ok  = ~os_mode | os_arm_q;
	assign os_arm_d = os_mode & (ospt_wr | (os_arm_q & ~match0));
	always_comb begin
		ff_d = ff_q;
		if (lvs_wr) begin
			ff_d = 1'b1;
		end else if (lvr_wr) begin
			ff_d = 1'b0;
		end else if (tog_evt & tog_ok) begin
			ff_d = ~ff_q;
		end
	end

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	assign tmc_d = wr_tmc ? tmc_wv[3:0] & TMC_MASK[3:0] : tmc_q;
	assign prm_d = wr_prm ? prm_wv & PRM_MASK : prm_q;
	assign crc_d = wr_crc ? crc_wv[2:0] & CRC_MASK[2:0] : crc_q;
	// set, reset and trigger act once and are never stored
	assign toc_d = wr_toc ? toc_wv & TOC_KEEP : toc_q;

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	always_comb begin
		case (cpu_addr)
			ADDR_CR0: rdata_d = cr0_q;
			ADDR_CR1: rdata_d = cr1_q;
			ADDR_TMC: rdata_d = {8'h00, tmc_cur};
			ADDR_PRM: rdata_d = {8'h00, prm_q};
			ADDR_CRC: rdata_d = {13'h0000, crc_q};
			ADDR_TOC: rdata_d = {8'h00, toc_cur};
			default:  rdata_d = 16'h0000;
		endcase
	end

	// ----------------------------------------------------------------
	// flip-flops
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tmc_q <= TMC_RST[3:0];
			prm_q <= PRM_RST;
			crc_q <= CRC_RST[2:0];
			toc_q <= TOC_RST;
			cr0_q <= CR_RST;
			cr1_q <= CR_RST;
			ovf_q <= TMC_RST[TMC_OVF];
		end else begin
			tmc_q <= tmc_d;
			prm_q <= prm_d;
			crc_q <= crc_d;
			toc_q <= toc_d;
			cr0_q <= cr0_d;
			cr1_q <= cr1_d;
			ovf_q <= ovf_d;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q       <= CNT_ZERO;
			ovf_win_q   <= 1'b0;
			clr_pend_q  <= 1'b0;
			cap0_pend_q <= 1'b0;
			cap1_pend_q <= 1'b0;
			irq0_pend_q <= 1'b0;
			irq1_pend_q <= 1'b0;
		end else begin
			cnt_q       <= cnt_d;
			ovf_win_q   <= ovf_win_d;
			clr_pend_q  <= clr_pend_d;
			cap0_pend_q <= cap0_pend_d;
			cap1_pend_q <= cap1_pend_d;
			irq0_pend_q <= irq0_pend_d;
			irq1_pend_q <= irq1_pend_d;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ff_q                <= 1'b0;
			os_arm_q            <= 1'b0;
			timer_output_pin    <= 1'b0;
			match_capture_irq_a <= 1'b0;
			match_capture_irq_b <= 1'b0;
			cpu_rdata           <= 16'h0000;
		end else begin
			ff_q                <= ff_d;
			os_arm_q            <= os_arm_d;
			timer_output_pin    <= toe & ff_d;
			match_capture_irq_a <= irq0_d;
			match_capture_irq_b <= irq1_d;
			cpu_rdata           <= cpu_rd ? rdata_d : cpu_rdata;
		end
	end
endmodule : tmr_ctrl
`default_nettype wire

// >>> core/tmr_pkg.sv
// constants, field positions and enumerations of the 16-bit timer control block
package tmr_pkg;

	// ----------------------------------------------------------------
	// register addresses
	// ----------------------------------------------------------------
	localparam logic [15:0] ADDR_CR0 = 16'hff14;
	localparam logic [15:0] ADDR_CR1 = 16'hff16;
	localparam logic [15:0] ADDR_TMC = 16'hff60;
	localparam logic [15:0] ADDR_PRM = 16'hff61;
	localparam logic [15:0] ADDR_CRC = 16'hff62;
	localparam logic [15:0] ADDR_TOC = 16'hff63;

	// ----------------------------------------------------------------
	// reset values and masks
	// ----------------------------------------------------------------
	localparam logic [7:0]  TMC_RST  = 8'h00;
	localparam logic [7:0]  PRM_RST  = 8'h00;
	localparam logic [7:0]  CRC_RST  = 8'h00;
	localparam logic [7:0]  TOC_RST  = 8'h00;
	localparam logic [15:0] CR_RST   = 16'h0000;
	localparam logic [7:0]  TMC_MASK = 8'h0f;
	localparam logic [7:0]  PRM_MASK = 8'hf3;
	localparam logic [7:0]  CRC_MASK = 8'h07;
	localparam logic [7:0]  TOC_KEEP = 8'h33;
	localparam logic [15:0] CNT_MAX  = 16'hffff;
	localparam logic [15:0] CNT_ZERO = 16'h0000;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int TMC_OVF     = 0;
	localparam int TMC_INV     = 1;
	localparam int TMC_MODE_LO = 2;
	localparam int CRC_CAP0    = 0;
	localparam int CRC_TRIG0   = 1;
	localparam int CRC_CAP1    = 2;
	localparam int TOC_TOE     = 0;
	localparam int TOC_INV0    = 1;
	localparam int TOC_LVR     = 2;
	localparam int TOC_LVS     = 3;
	localparam int TOC_INV1    = 4;
	localparam int TOC_OSPE    = 5;
	localparam int TOC_OSPT    = 6;
	localparam int PRM_CKS_LO  = 0;
	localparam int PRM_ES0_LO  = 4;
	localparam int PRM_ES1_LO  = 6;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int PRESC_MID  = 4;
	localparam int PRESC_SLOW = 256;

	typedef enum logic [1:0] {MODE_STOP, MODE_FREE, MODE_CLR_EDGE, MODE_CLR_MATCH} tmr_mode_t;
	typedef enum logic [1:0] {EDGE_FALL, EDGE_RISE, EDGE_BAD, EDGE_BOTH} tmr_edge_t;
	typedef enum logic [1:0] {CKS_FXP, CKS_MID, CKS_SLOW, CKS_EXT} tmr_cks_t;

endpackage : tmr_pkg

// >>> core/tmr_pin_sync.sv
// three-stage synchroniser and edge detector for one timer input pin
`timescale 1ns/100ps
`default_nettype none
module tmr_pin_sync (
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic pin,
	output logic      rise,
	output logic      fall
);
	import tmr_pkg::*;

	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic lvl_q;
	logic lvl_d;

	// a change counts only when the last two stages agree
	assign lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s1_q  <= 1'b0;
			s2_q  <= 1'b0;
			s3_q  <= 1'b0;
			lvl_q <= 1'b0;
			rise  <= 1'b0;
			fall  <= 1'b0;
		end else begin
			s1_q  <= pin;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			lvl_q <= lvl_d;
			rise  <= lvl_d & ~lvl_q;
			fall  <= ~lvl_d & lvl_q;
		end
	end
endmodule : tmr_pin_sync
`default_nettype wire

// >>> core/tmr_count_tick.sv
// count clock enable: peripheral clock, two divided rates or external edge
`timescale 1ns/100ps
`default_nettype none
module tmr_count_tick #(
	parameter int DIV_MID  = tmr_pkg::PRESC_MID,
	parameter int DIV_SLOW = tmr_pkg::PRESC_SLOW
) (
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic             run,
	input  wire tmr_pkg::tmr_cks_t sel,
	input  wire logic             ext_edge,
	output logic                  tick
);
	import tmr_pkg::*;

	localparam int W = $clog2(DIV_SLOW);

	if (DIV_MID < 2 || DIV_SLOW <= DIV_MID || (DIV_MID & (DIV_MID - 1)) != 0 ||
	    (DIV_SLOW & (DIV_SLOW - 1)) != 0) begin : g_chk
		$error("divider ratios must be powers of two with DIV_SLOW above DIV_MID");
	end

	logic [W-1:0] div_q;
	logic         mid_hit;
	logic         slow_hit;
	logic         tick_d;

	localparam logic [W-1:0] MID_MASK = W'(DIV_MID - 1);

	assign mid_hit  = (div_q & MID_MASK) == '0;
	assign slow_hit = div_q == '0;
	assign tick_d   = run & ((sel == CKS_FXP) | (sel == CKS_MID & mid_hit) |
	                         (sel == CKS_SLOW & slow_hit) | (sel == CKS_EXT & ext_edge));

	// divider restarts whenever the timer stops so the first tick comes one cycle after the start
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			div_q <= '0;
			tick  <= 1'b0;
		end else begin
			div_q <= run ? div_q + W'(1) : '0;
			tick  <= tick_d;
		end
	end
endmodule : tmr_count_tick
`default_nettype wire

// >>> dv/tmr_ctrl_chk.sv
// port-level assertion checker for the timer control block
`timescale 1ns/100ps
`default_nettype none
module tmr_ctrl_chk
	import tmr_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic [15:0] cpu_addr,
	input wire logic        cpu_wr,
	input wire logic        cpu_bit_wr,
	input wire logic [2:0]  cpu_bit_sel,
	input wire logic        cpu_bit_val,
	input wire logic [15:0] cpu_wdata,
	input wire logic        cpu_rd,
	input wire logic [15:0] cpu_rdata,
	input wire logic        timer_input_a,
	input wire logic        timer_input_b,
	input wire logic        timer_output_pin,
	input wire logic        match_capture_irq_a,
	input wire logic        match_capture_irq_b
);
	// shadow of the mode bits; a late tick may still land an irq, so wait 3 cycles
	logic [1:0] mode_q;
	logic [1:0] stop_q;
	wire        tmc_w  = cpu_addr == ADDR_TMC;
	wire        mbit_w = cpu_bit_wr && tmc_w && cpu_bit_sel[2:1] == 2'h1;
	wire [1:0]  mbit_v = cpu_bit_sel[0] ? {cpu_bit_val, mode_q[0]} : {mode_q[1], cpu_bit_val};
	wire [1:0]  mode_d = (cpu_wr && tmc_w) ? cpu_wdata[3:2] : (mbit_w ? mbit_v : mode_q);
	wire [1:0]  stop_d = (mode_q != 2'h0) ? 2'h0 : ((stop_q == 2'h3) ? stop_q : stop_q + 2'h1);
	wire [2:0]  wlo    = cpu_wdata[2:0];
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_q <= 2'h0;
			stop_q <= 2'h0;
		end else begin
			mode_q <= mode_d;
			stop_q <= stop_d;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence crc_wr_s; cpu_wr && cpu_addr == ADDR_CRC; endsequence
	sequence crc_rd_s; cpu_rd && cpu_addr == ADDR_CRC; endsequence
	sequence inv_bit_s; cpu_bit_wr && tmc_w && cpu_bit_sel == 3'h1; endsequence
	sequence tmc_rd_s; cpu_rd && tmc_w; endsequence
	rst_quiet_a: assert property ($rose(rst_b) |-> !match_capture_irq_a && !match_capture_irq_b && !timer_output_pin)
		else $error("outputs active right after reset");
	stop_quiet_a: assert property (stop_q == 2'h3 |-> !match_capture_irq_a && !match_capture_irq_b)
		else $error("interrupt while stopped");
	stop_hold_a: assert property (stop_q == 2'h3 && !$past(cpu_wr) && !$past(cpu_bit_wr) |-> $stable(timer_output_pin))
		else $error("output moved while stopped");
	crc_wrrd_a: assert property (crc_wr_s ##2 crc_rd_s |=> cpu_rdata[2:0] == $past(wlo, 3))
		else $error("capture control bits not kept");
	crc_rsvd_a: assert property (crc_rd_s |=> cpu_rdata[15:3] == 13'h0)
		else $error("capture control reserved bits set");
	tmc_bitwr_a: assert property (inv_bit_s ##2 tmc_rd_s |=> cpu_rdata[1] == $past(cpu_bit_val, 3))
		else $error("single-bit mode write lost");
	tmc_rsvd_a: assert property (tmc_rd_s |=> cpu_rdata[15:4] == 12'h0)
		else $error("mode control reserved bits set");
	toc_trig_a: assert property (cpu_rd && cpu_addr == ADDR_TOC |=> cpu_rdata[15:6] == 10'h0 && cpu_rdata[3:2] == 2'h0)
		else $error("one-shot or level bits read nonzero");
endmodule : tmr_ctrl_chk
bind tmr_ctrl tmr_ctrl_chk chk (.clk(clk), .rst_b(rst_b), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
	.cpu_bit_wr(cpu_bit_wr), .cpu_bit_sel(cpu_bit_sel), .cpu_bit_val(cpu_bit_val),
	.cpu_wdata(cpu_wdata), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata),
	.timer_input_a(timer_input_a), .timer_input_b(timer_input_b),
	.timer_output_pin(timer_output_pin), .match_capture_irq_a(match_capture_irq_a),
	.match_capture_irq_b(match_capture_irq_b));
`default_nettype wire

// >>> dv/tmr_pins_model.sv
// external pin driver standing in for the timer input sources
`timescale 1ns/100ps
`default_nettype none
module tmr_pins_model (
	input  wire logic clk,
	output var logic  pin_a,
	output var logic  pin_b
);
	initial begin
		pin_a = 1'b0;
		pin_b = 1'b0;
	end
	// six clocks per level: shorter pulses may be dropped by the noise filter
	task automatic pulse(input logic sel_b);
		@(posedge clk);
		if (sel_b) pin_b <= 1'b1;
		else pin_a <= 1'b1;
		repeat (6) @(posedge clk);
		if (sel_b) pin_b <= 1'b0;
		else pin_a <= 1'b0;
		repeat (6) @(posedge clk);
	endtask : pulse
endmodule : tmr_pins_model
`default_nettype wire

// >>> dv/tmr_ctrl_bench.sv
// self-checking bench for the timer control block
`timescale 1ns/100ps
`default_nettype none
module tmr_ctrl_bench;
	import tmr_pkg::*;
	logic        clk;
	logic        rst_b;
	logic [15:0] cpu_addr;
	logic        cpu_wr;
	logic        cpu_bit_wr;
	logic [2:0]  cpu_bit_sel;
	logic        cpu_bit_val;
	logic [15:0] cpu_wdata;
	logic        cpu_rd;
	logic [15:0] cpu_rdata;
	logic        pin_a;
	logic        pin_b;
	logic        pin_o;
	logic        irq_a;
	logic        irq_b;
	logic        p;
	int          fails;
	int          n_tests;
	int          cyc;
	int          n;
	logic [7:0]  cap_prm [4] = '{8'h10, 8'h30, 8'h10, 8'h00};
	logic [7:0]  cap_crc [4] = '{8'h04, 8'h03, 8'h03, 8'h01};
	logic        cap_pin [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
	logic        cap_irq [4] = '{1'b1, 1'b0, 1'b0, 1'b0};
	logic        cap_hit [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
	tmr_ctrl dut (.clk(clk), .rst_b(rst_b), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
		.cpu_bit_wr(cpu_bit_wr), .cpu_bit_sel(cpu_bit_sel), .cpu_bit_val(cpu_bit_val),
		.cpu_wdata(cpu_wdata), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata),
		.timer_input_a(pin_a), .timer_input_b(pin_b), .timer_output_pin(pin_o),
		.match_capture_irq_a(irq_a), .match_capture_irq_b(irq_b));
	tmr_pins_model m (.clk(clk), .pin_a(pin_a), .pin_b(pin_b));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ----------------------------------------------------------------
	// access and check tasks
	// ----------------------------------------------------------------
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : final_report
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		cpu_addr  <= a;
		cpu_wdata <= d;
		cpu_wr    <= 1'b1;
		@(posedge clk);
		cpu_wr <= 1'b0;
	endtask : wr
	task automatic bwr(input logic [15:0] a, input logic [2:0] s, input logic b);
		@(posedge clk);
		cpu_addr    <= a;
		cpu_bit_sel <= s;
		cpu_bit_val <= b;
		cpu_bit_wr  <= 1'b1;
		@(posedge clk);
		cpu_bit_wr <= 1'b0;
	endtask : bwr
	task automatic rdc(input string nm, input logic [15:0] a, input logic [15:0] e);
		@(posedge clk);
		cpu_addr <= a;
		cpu_rd   <= 1'b1;
		@(posedge clk);
		cpu_rd <= 1'b0;
		#1;
		chk(nm, e, cpu_rdata);
	endtask : rdc
	// returns lim when the interrupt never came
	task automatic await(input logic sel_b, input int lim, output int k);
		k = 0;
		do begin
			@(posedge clk);
			#1;
			k++;
		end while ((sel_b ? irq_b : irq_a) !== 1'b1 && k < lim);
	endtask : await
	always @(posedge clk) begin
		cyc++;
		if (cyc == 80000) begin
			fails++;
			$display("mismatch run length expected under 80000 seen 80000");
			final_report();
		end
	end
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		{fails, n_tests, cyc} = '0;
		{rst_b, cpu_wr, cpu_bit_wr, cpu_bit_val, cpu_rd} = '0;
		{cpu_addr, cpu_wdata, cpu_bit_sel} = '0;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		rdc("mode ctl", ADDR_TMC, 16'h0000);
		rdc("capcomp ctl", ADDR_CRC, 16'h0000);
		rdc("output ctl", ADDR_TOC, 16'h0000);
		rdc("unmapped", 16'hff70, 16'h0000);
		wr(ADDR_CRC, 16'h00ff);
		rdc("capcomp bits", ADDR_CRC, 16'h0007);
		bwr(ADDR_TMC, 3'h1, 1'b1);
		rdc("inversion bit", ADDR_TMC, 16'h0002);
		wr(ADDR_TOC, 16'h0067);
		rdc("one-shot trigger", ADDR_TOC, 16'h0023);
		wr(ADDR_TOC, 16'h0003);
		wr(ADDR_CRC, 16'h0000);
		wr(ADDR_CR0, 16'h0010);
		wr(ADDR_TMC, 16'h000c);
		await(1'b0, 100, n);
		await(1'b0, 100, n);
		chk("match period", 16'd17, 16'(n));
		repeat (8) @(posedge clk);
		p = pin_o;
		await(1'b0, 100, n);
		repeat (8) @(posedge clk);
		chk("match toggle", {15'h0, ~p}, {15'h0, pin_o});
		wr(ADDR_TMC, 16'h0000);
		fork
			m.pulse(1'b0);
			await(1'b0, 30, n);
		join
		chk("stopped irq", 16'd30, 16'(n));
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_TMC, 16'h0000);
			wr(ADDR_PRM, {8'h00, cap_prm[i]});
			wr(ADDR_CRC, {8'h00, cap_crc[i]});
			wr(ADDR_TMC, 16'h0004);
			fork
				m.pulse(cap_pin[i]);
				await(cap_irq[i], 40, n);
			join
			chk("capture irq", {15'h0, cap_hit[i]}, {15'h0, n < 40});
		end
		wr(ADDR_TMC, 16'h0000);
		wr(ADDR_PRM, 16'h0010);
		wr(ADDR_CRC, 16'h0000);
		wr(ADDR_CR0, 16'h0400);
		wr(ADDR_TMC, 16'h000a);
		repeat (20) @(posedge clk);
		p = pin_o;
		fork
			m.pulse(1'b0);
			await(1'b1, 40, n);
		join
		chk("edge clear irq", 16'h0001, {15'h0, n < 40});
		chk("edge toggle", {15'h0, ~p}, {15'h0, pin_o});
		wr(ADDR_TMC, 16'h0000);
		wr(ADDR_CR0, 16'hffff);
		wr(ADDR_TMC, 16'h000c);
		await(1'b0, 70000, n);
		chk("overflow wait", 16'h0001, {15'h0, n < 70000});
		// flag is read while still running: a stop write would clear it
		repeat (5) @(posedge clk);
		rdc("overflow set", ADDR_TMC, 16'h000d);
		bwr(ADDR_TMC, 3'h0, 1'b0);
		rdc("overflow cleared", ADDR_TMC, 16'h000c);
		for (int i = 1; i < 3; i++) begin
			wr(ADDR_TMC, 16'h0000);
			wr(ADDR_PRM, 16'(i));
			wr(ADDR_CR0, 16'h0003);
			wr(ADDR_TMC, 16'h000c);
			await(1'b0, 1100, n);
			await(1'b0, 1100, n);
			chk("divided period", 16'(4 * (i == 1 ? PRESC_MID : PRESC_SLOW)), 16'(n));
		end
		// input a edges as the count clock: two rising edges reach a match at 1
		wr(ADDR_TMC, 16'h0000);
		wr(ADDR_PRM, 16'h0013);
		wr(ADDR_CR0, 16'h0001);
		wr(ADDR_TMC, 16'h000c);
		fork
			begin
				m.pulse(1'b0);
				m.pulse(1'b0);
			end
			await(1'b0, 40, n);
		join
		chk("event count", 16'd20, 16'(n));
		wr(ADDR_TMC, 16'h0000);
		final_report();
	end
endmodule : tmr_ctrl_bench
`default_nettype wire
